// File: design/sfcf_defs.svh
`ifndef SFCF_DEFS_SVH
`define SFCF_DEFS_SVH

// ==========================================================
// opcodes: array reads
`define SFCF_OP_READ_SLOW   8'h03
`define SFCF_OP_READ_FAST   8'h0B
`define SFCF_OP_READ_DUAL   8'h3B

// ==========================================================
// opcodes: framed with three address bytes
`define SFCF_OP_PAGE_PROG   8'h02
`define SFCF_OP_DUAL_PROG   8'hA2
`define SFCF_OP_PAGE_ERASE  8'h81
`define SFCF_OP_ERASE_4K    8'h20
`define SFCF_OP_ERASE_32K   8'h52
`define SFCF_OP_ERASE_64K   8'hD8
`define SFCF_OP_PROTECT     8'h36
`define SFCF_OP_UNPROTECT   8'h39
`define SFCF_OP_OTP_PROG    8'h9B

// ==========================================================
// opcodes: opcode only, optional data bytes in
`define SFCF_OP_WR_EN       8'h06
`define SFCF_OP_WR_DIS      8'h04
`define SFCF_OP_CHIP_ERA_A  8'h60
`define SFCF_OP_CHIP_ERA_B  8'hC7
`define SFCF_OP_STAT_RD     8'h05
`define SFCF_OP_STAT_WR1    8'h01
`define SFCF_OP_STAT_WR2    8'h31
`define SFCF_OP_SOFT_RST    8'hF0
`define SFCF_OP_ID_RD       8'h9F
`define SFCF_OP_PWR_DOWN    8'hB9
`define SFCF_OP_PWR_RESUME  8'hAB
`define SFCF_OP_PWR_ULTRA   8'h79

// ==========================================================
// addressing
`define SFCF_AW             19
`define SFCF_ADDR_MAX       19'h7FFFF
`define SFCF_ADDR_ZERO      19'h00000
`define SFCF_ADDR_ONE       19'h00001
`define SFCF_PAGE_LSB       8
`define SFCF_BLOCK_LSB      12
`define SFCF_ADDR_LAST_BYTE 2'h2

// ==========================================================
// bit framing
`define SFCF_BIT_LAST       3'h7
`define SFCF_PAIR_LAST      3'h3
`define SFCF_BIT_ZERO       3'h0
`define SFCF_BYTE_FILL      8'hFF
`define SFCF_SYNC_RST       3'h4

`endif

// File: design/sfcf_pkg.sv
package sfcf_pkg;

    // gray coded along idle, opcode, address, dummy, data out
    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_OPC    = 3'h1,
        ST_ADDR   = 3'h3,
        ST_DUMMY  = 3'h2,
        ST_DOUT   = 3'h6,
        ST_DIN    = 3'h7,
        ST_IGNORE = 3'h5
    } sfcf_state_e;

endpackage

// File: design/sfcf_sync.sv
`timescale 1ns/1ps
`default_nettype none

module sfcf_sync #(
    parameter int               WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // clock and reset
    input  wire logic             i_ref_clk,
    input  wire logic             i_resetn,
    // levels
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            meta_reg <= RST_VAL;
            o_sync   <= RST_VAL;
        end else begin
            meta_reg <= i_async;
            o_sync   <= meta_reg;
        end
    end

endmodule // sfcf_sync

`default_nettype wire

// File: design/sfcf_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module sfcf_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             i_ref_clk,
    input  wire logic             i_resetn,
    input  wire logic             i_flush,
    // fill side
    input  wire logic [WIDTH-1:0] i_in_data,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    // drain side
    output logic      [WIDTH-1:0] o_out_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    wire              push = i_in_valid & o_in_ready;
    wire              pop  = o_out_valid & i_out_ready;

    assign o_in_ready  = (count_reg != (AW+1)'(DEPTH)) & ~i_flush;
    assign o_out_valid = (count_reg != '0) & ~i_flush;
    assign o_out_data  = mem[rd_ptr_reg];

    always_ff @(posedge i_ref_clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= i_in_data;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else if (i_flush) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            wr_ptr_reg <= push ? AW'((wr_ptr_reg + 1'b1) % DEPTH) : wr_ptr_reg;
            rd_ptr_reg <= pop ? AW'((rd_ptr_reg + 1'b1) % DEPTH) : rd_ptr_reg;
            count_reg  <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule // sfcf_fifo

`default_nettype wire

// File: design/sfcf_frontend.sv
// What this block does
// - work in serial modes 0 and 3; idle clock level does not matter
// - sample input on rising clock edge, launch output on falling edge
// - dual read drives two bits per clock, input pin becomes an output
// - all opcode, address and data bytes move most significant bit first
// - chip select release ends the operation
// - unsupported opcode starts nothing and changes no internal state
// - after unsupported opcode, ignore input until chip select toggles
// - release before opcode and address complete does nothing, back to idle
// - address is three bytes, bits 23 to 0, high byte first
// - address bits 23 to 19 ignored, array ends at 07FFFFh
// - 4 KB blocks and 256-byte pages sit at aligned address ranges
// - second page at 000100h, second block at 001000h
// - fast read 0Bh takes one dummy byte, slow read 03h none
// - continuous read wraps from 07FFFFh to 000000h without delay
// - chip select release stops output at once and floats the pin
`include "sfcf_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module sfcf_frontend
    import sfcf_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
) (
    // clock and reset
    input  wire logic                   i_ref_clk,
    input  wire logic                   i_resetn,
    // serial link
    input  wire logic                   i_cs_n,
    input  wire logic                   i_sck,
    input  wire logic                   i_si,
    output logic                        o_si,
    output logic                        o_si_oe,
    output logic                        o_so,
    output logic                        o_so_oe,
    // array read stream
    input  wire logic [7:0]             i_fill_data,
    input  wire logic                   i_fill_valid,
    output logic                        o_fill_ready,
    output logic                        o_rd_start,
    output logic                        o_rd_busy,
    output logic [`SFCF_AW-1:0]         o_rd_addr,
    output logic [`SFCF_AW-`SFCF_PAGE_LSB-1:0]  o_rd_page,
    output logic [`SFCF_AW-`SFCF_BLOCK_LSB-1:0] o_rd_block,
    output logic                        o_underrun,
    // framed commands and write data
    output logic                        o_cmd_valid,
    output logic [7:0]                  o_cmd_opcode,
    output logic [`SFCF_AW-1:0]         o_cmd_addr,
    output logic                        o_cmd_has_addr,
    output logic                        o_wr_valid,
    output logic [7:0]                  o_wr_data
);

    // ==========================================================
    // pin synchronisers and edge detection
    logic [2:0]  pins_s;
    logic        sck_d_reg;
    wire         cs_n_s   = pins_s[2];
    wire         sck_s    = pins_s[1];
    wire         si_s     = pins_s[0];
    // the link clock is slow against ours, so sampled edges suffice
    wire         sck_rise = sck_s & ~sck_d_reg;
    wire         sck_fall = ~sck_s & sck_d_reg;

    sfcf_sync #(
        .WIDTH   (3),
        .RST_VAL (`SFCF_SYNC_RST)
    ) u_sync (
        .i_ref_clk (i_ref_clk),
        .i_resetn  (i_resetn),
        .i_async   ({i_cs_n, i_sck, i_si}),
        .o_sync    (pins_s)
    );

    // mode 0 and mode 3 need no distinction: only edges are used
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sck_d_reg <= 1'b0;
        end else begin
            sck_d_reg <= sck_s;
        end
    end

    // ==========================================================
    // state and input shifting
    sfcf_state_e        state_reg;
    sfcf_state_e        state_next;
    logic [2:0]         bit_cnt_reg;
    logic [1:0]         byte_cnt_reg;
    logic [7:0]         in_sh_reg;
    logic [7:0]         opc_reg;
    logic               dual_reg;
    logic [15:0]        addr_reg;

    wire  [7:0]  in_byte   = {in_sh_reg[6:0], si_s};
    wire         byte_done = sck_rise & ~cs_n_s & (bit_cnt_reg == `SFCF_BIT_LAST);
    wire         in_opc    = (state_reg == ST_OPC);
    wire  [7:0]  dec_op    = in_opc ? in_byte : opc_reg;

    // ==========================================================
    // opcode decode
    wire op_read  = (dec_op == `SFCF_OP_READ_SLOW) | (dec_op == `SFCF_OP_READ_FAST)
                  | (dec_op == `SFCF_OP_READ_DUAL);
    wire op_dummy = (dec_op == `SFCF_OP_READ_FAST) | (dec_op == `SFCF_OP_READ_DUAL);
    wire op_addr  = op_read
                  | (dec_op == `SFCF_OP_PAGE_PROG)  | (dec_op == `SFCF_OP_DUAL_PROG)
                  | (dec_op == `SFCF_OP_PAGE_ERASE) | (dec_op == `SFCF_OP_ERASE_4K)
                  | (dec_op == `SFCF_OP_ERASE_32K)  | (dec_op == `SFCF_OP_ERASE_64K)
                  | (dec_op == `SFCF_OP_PROTECT)    | (dec_op == `SFCF_OP_UNPROTECT)
                  | (dec_op == `SFCF_OP_OTP_PROG);
    wire op_plain = (dec_op == `SFCF_OP_WR_EN)      | (dec_op == `SFCF_OP_WR_DIS)
                  | (dec_op == `SFCF_OP_CHIP_ERA_A) | (dec_op == `SFCF_OP_CHIP_ERA_B)
                  | (dec_op == `SFCF_OP_STAT_RD)    | (dec_op == `SFCF_OP_STAT_WR1)
                  | (dec_op == `SFCF_OP_STAT_WR2)   | (dec_op == `SFCF_OP_SOFT_RST)
                  | (dec_op == `SFCF_OP_ID_RD)      | (dec_op == `SFCF_OP_PWR_DOWN)
                  | (dec_op == `SFCF_OP_PWR_RESUME) | (dec_op == `SFCF_OP_PWR_ULTRA);
    wire op_ok    = op_addr | op_plain;

    wire opc_done  = byte_done & in_opc;
    wire addr_done = byte_done & (state_reg == ST_ADDR) & (byte_cnt_reg == `SFCF_ADDR_LAST_BYTE);
    // upper five address bits fall away here
    wire [`SFCF_AW-1:0] full_addr = `SFCF_AW'({addr_reg[15:0], in_byte});
    wire cmd_fire  = (opc_done & op_plain) | (addr_done & ~op_read);
    wire read_fire = addr_done & op_read;

    always_comb begin
        state_next = state_reg;
        if (cs_n_s) begin
            state_next = ST_IDLE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    state_next = ST_OPC;
                end
                ST_OPC: begin
                    if (opc_done) begin
                        if (!op_ok) begin
                            state_next = ST_IGNORE;
                        end else if (op_addr) begin
                            state_next = ST_ADDR;
                        end else begin
                            state_next = ST_DIN;
                        end
                    end
                end
                ST_ADDR: begin
                    if (addr_done) begin
                        if (op_dummy) begin
                            state_next = ST_DUMMY;
                        end else if (op_read) begin
                            state_next = ST_DOUT;
                        end else begin
                            state_next = ST_DIN;
                        end
                    end
                end
                ST_DUMMY: begin
                    if (byte_done) begin
                        state_next = ST_DOUT;
                    end
                end
                default: begin
                    state_next = state_reg;
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_reg    <= ST_IDLE;
            bit_cnt_reg  <= `SFCF_BIT_ZERO;
            byte_cnt_reg <= 2'h0;
            in_sh_reg    <= 8'h00;
        end else begin
            state_reg    <= state_next;
            bit_cnt_reg  <= cs_n_s ? `SFCF_BIT_ZERO : bit_cnt_reg + 3'(sck_rise);
            byte_cnt_reg <= cs_n_s ? 2'h0 : byte_cnt_reg + 2'(byte_done & (state_reg == ST_ADDR));
            in_sh_reg    <= sck_rise ? in_byte : in_sh_reg;
        end
    end

    // opcode and address held only for supported commands
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            opc_reg  <= 8'h00;
            dual_reg <= 1'b0;
            addr_reg <= 16'h0000;
        end else begin
            if (opc_done & op_ok) begin
                opc_reg  <= in_byte;
                dual_reg <= (in_byte == `SFCF_OP_READ_DUAL);
            end
            if (byte_done & (state_reg == ST_ADDR)) begin
                addr_reg <= {addr_reg[7:0], in_byte};
            end
        end
    end

    // ==========================================================
    // command and write-data outputs
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_cmd_valid    <= 1'b0;
            o_cmd_opcode   <= 8'h00;
            o_cmd_addr     <= `SFCF_ADDR_ZERO;
            o_cmd_has_addr <= 1'b0;
            o_wr_valid     <= 1'b0;
            o_wr_data      <= 8'h00;
        end else begin
            o_cmd_valid <= cmd_fire;
            if (cmd_fire) begin
                o_cmd_opcode   <= dec_op;
                o_cmd_addr     <= addr_done ? full_addr : `SFCF_ADDR_ZERO;
                o_cmd_has_addr <= addr_done;
            end
            o_wr_valid <= byte_done & (state_reg == ST_DIN);
            o_wr_data  <= (byte_done & (state_reg == ST_DIN)) ? in_byte : o_wr_data;
        end
    end

    // ==========================================================
    // read stream buffer, refilled by the array side
    logic [7:0] fifo_data;
    logic       fifo_valid;
    logic [2:0] obit_reg;
    logic [7:0] out_sh_reg;
    logic       oe_reg;
    logic       si_oe_reg;

    wire        out_fall = sck_fall & (state_reg == ST_DOUT) & ~cs_n_s;
    wire        out_load = out_fall & (obit_reg == `SFCF_BIT_ZERO);
    // an empty buffer sends filler rather than stalling the host clock
    wire  [7:0] load_byte = fifo_valid ? fifo_data : `SFCF_BYTE_FILL;
    wire  [7:0] out_src   = out_load ? load_byte : out_sh_reg;
    wire  [7:0] out_shift = dual_reg ? {out_src[5:0], 2'h0} : {out_src[6:0], 1'h0};
    wire  [2:0] obit_next = out_load ? (dual_reg ? `SFCF_PAIR_LAST : `SFCF_BIT_LAST) : obit_reg - 3'h1;
    wire [`SFCF_AW-1:0] addr_inc = (o_rd_addr == `SFCF_ADDR_MAX) ? `SFCF_ADDR_ZERO
                                 : o_rd_addr + `SFCF_ADDR_ONE;

    sfcf_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_ref_clk   (i_ref_clk),
        .i_resetn    (i_resetn),
        .i_flush     (cs_n_s),
        .i_in_data   (i_fill_data),
        .i_in_valid  (i_fill_valid),
        .o_in_ready  (o_fill_ready),
        .o_out_data  (fifo_data),
        .o_out_valid (fifo_valid),
        .i_out_ready (out_load)
    );

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rd_start <= 1'b0;
            o_rd_busy  <= 1'b0;
            o_rd_addr  <= `SFCF_ADDR_ZERO;
            o_underrun <= 1'b0;
        end else begin
            o_rd_start <= read_fire;
            o_rd_busy  <= ~cs_n_s & (o_rd_busy | read_fire);
            o_underrun <= out_load & ~fifo_valid;
            if (read_fire) begin
                o_rd_addr <= full_addr;
            end else if (out_load) begin
                o_rd_addr <= addr_inc;
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            obit_reg   <= `SFCF_BIT_ZERO;
            out_sh_reg <= 8'h00;
            o_so       <= 1'b0;
            o_si       <= 1'b0;
            oe_reg     <= 1'b0;
            si_oe_reg  <= 1'b0;
        end else if (cs_n_s) begin
            obit_reg  <= `SFCF_BIT_ZERO;
            oe_reg    <= 1'b0;
            si_oe_reg <= 1'b0;
        end else if (out_fall) begin
            o_so       <= out_src[7];
            o_si       <= out_src[6];
            out_sh_reg <= out_shift;
            obit_reg   <= obit_next;
            oe_reg     <= 1'b1;
            si_oe_reg  <= dual_reg;
        end
    end

    assign o_so_oe    = oe_reg;
    assign o_si_oe    = si_oe_reg;
    // page and block indices of the byte fetched next
    assign o_rd_page  = o_rd_addr[`SFCF_AW-1:`SFCF_PAGE_LSB];
    assign o_rd_block = o_rd_addr[`SFCF_AW-1:`SFCF_BLOCK_LSB];

    // ==========================================================
    // assertions
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_resetn);

    a_si_drive_dual: assert property (o_si_oe |-> (state_reg == ST_DOUT) && dual_reg)
        else $error("input pin driven outside dual read");
    a_so_oe_read: assert property (o_so_oe |-> (state_reg == ST_DOUT) || (state_reg == ST_IDLE))
        else $error("output pin driven outside read data");
    a_release_float: assert property ($rose(cs_n_s) |=> !o_so_oe && !o_si_oe)
        else $error("output not floated after chip select release");
    a_release_idle: assert property (cs_n_s |=> state_reg == ST_IDLE)
        else $error("no return to idle on release");
    a_abort_quiet: assert property ((state_reg == ST_ADDR) && cs_n_s |=> !o_rd_start && !o_cmd_valid)
        else $error("operation started after early release");
    a_ignore_quiet: assert property ((state_reg == ST_IGNORE) |=> $stable(opc_reg) && $stable(addr_reg)
                                     && !o_cmd_valid && !o_wr_valid && !o_rd_start)
        else $error("unsupported opcode changed state");
    a_unsup_enter: assert property (opc_done && !op_ok |=> state_reg == ST_IGNORE && $stable(opc_reg))
        else $error("unsupported opcode not ignored");
    a_dummy_fast: assert property (read_fire && op_dummy |=> state_reg == ST_DUMMY)
        else $error("fast read skipped its dummy byte");
    a_wrap_zero: assert property (out_load && (o_rd_addr == `SFCF_ADDR_MAX) |=> o_rd_addr == `SFCF_ADDR_ZERO)
        else $error("address did not wrap to zero");
    a_launch_fall: assert property ($changed(o_so) |-> $past(sck_fall))
        else $error("output bit changed away from a falling edge");
    a_dual_pairs: assert property (out_load && dual_reg && !cs_n_s |=> obit_reg == `SFCF_PAIR_LAST)
        else $error("dual byte not split into four pairs");

    c_slow_read: cover property (read_fire && (opc_reg == `SFCF_OP_READ_SLOW) ##[1:200] out_load);
    c_dual_read: cover property (o_si_oe ##1 $fell(o_si_oe));
    c_unsupported: cover property (state_reg == ST_IGNORE);
    c_early_release: cover property ((state_reg == ST_ADDR) ##1 cs_n_s);

endmodule // sfcf_frontend

`default_nettype wire

// File: sim/sfcf_host.sv
`timescale 1ns/1ps
`default_nettype none

// ====================
// host controller model, link clock 125 ns, still between frames
module sfcf_host (
    output logic      cs_n,
    output logic      sck,
    output logic      si,
    output logic      si_oe,
    input  wire logic so_pin,
    input  wire logic si_pin
);
    logic m3;

    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        si_oe = 1'b1;
        m3 = 1'b0;
    end

    task start(input logic mode3);
        m3 = mode3;
        sck = mode3;
        #100;
        cs_n = 1'b0;
        #62.5;
    endtask

    // si released for dual data so the device can drive it
    task xbyte(input logic [7:0] b, input logic dual, output logic [7:0] r);
        si_oe = !dual;
        for (int k = 0; k < (dual ? 4 : 8); k++) begin
            sck = 1'b0;
            si = b[7-k];
            #62.5;
            sck = 1'b1;
            if (dual)
                r[7-2*k -: 2] = {so_pin, si_pin};
            else
                r[7-k] = so_pin;
            #62.5;
        end
    endtask

    task stop();
        sck = m3;
        #62.5;
        cs_n = 1'b1;
        si_oe = 1'b1;
        #250;
    endtask
endmodule // sfcf_host

`default_nettype wire

// File: sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        cs_n, sck, h_si, h_oe, so, so_oe, d_si, d_si_oe;
    logic [7:0]  fd = 8'h00;
    logic        fv = 1'b0;
    logic [18:0] fa = 19'h00000;
    logic        fr, rd_start, rd_busy, und, cmd_v, cmd_ha, wr_v;
    logic [18:0] rd_addr, cmd_addr;
    logic [10:0] rd_page;
    logic [6:0]  rd_block;
    logic [7:0]  cmd_op, wr_d;
    // released lines show the inverse of their last level
    wire         so_pin = so_oe ? so : ~so;
    wire         si_pin = d_si_oe ? d_si : (h_oe ? h_si : ~h_si);
    int          n_mismatch = 0, check_count = 0, cyc = 0;
    int          n_rd = 0, n_cmd = 0, n_wr = 0, n_und = 0;

    always #5 clk = ~clk;

    sfcf_host h_u (.cs_n(cs_n), .sck(sck), .si(h_si), .si_oe(h_oe), .so_pin(so_pin), .si_pin(si_pin));

    sfcf_frontend #(.FIFO_DEPTH(16)) dut_u (
        .i_ref_clk(clk), .i_resetn(rst_n), .i_cs_n(cs_n), .i_sck(sck), .i_si(si_pin),
        .o_si(d_si), .o_si_oe(d_si_oe), .o_so(so), .o_so_oe(so_oe),
        .i_fill_data(fd), .i_fill_valid(fv), .o_fill_ready(fr), .o_rd_start(rd_start),
        .o_rd_busy(rd_busy), .o_rd_addr(rd_addr), .o_rd_page(rd_page), .o_rd_block(rd_block),
        .o_underrun(und), .o_cmd_valid(cmd_v), .o_cmd_opcode(cmd_op), .o_cmd_addr(cmd_addr),
        .o_cmd_has_addr(cmd_ha), .o_wr_valid(wr_v), .o_wr_data(wr_d));

    function automatic logic [7:0] fx(input logic [18:0] a);
        return a[7:0] ^ a[18:11];
    endfunction

    // ====================
    // array side: sequential bytes, stalls whenever the fifo is full
    always @(posedge clk) begin
        if (rd_start) begin
            fa <= rd_addr + 19'h00001;
            fd <= fx(rd_addr);
            fv <= 1'b1;
        end else if (!rd_busy) begin
            fv <= 1'b0;
        end else if (fr) begin
            fa <= fa + 19'h00001;
            fd <= fx(fa);
        end
    end

    always @(posedge clk) begin
        n_rd += rd_start;
        n_cmd += cmd_v;
        n_wr += wr_v;
        n_und += und;
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            results();
        end
    end

    // ====================
    // shared tasks
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    task rd(input logic [7:0] op, input logic [23:0] a, input logic m3, input int nb, input logic dual);
        logic [7:0]  r;
        logic [18:0] e;
        int          n0;
        n0 = n_rd;
        e = a[18:0];
        h_u.start(m3);
        h_u.xbyte(op, 1'b0, r);
        for (int i = 2; i >= 0; i--)
            h_u.xbyte(a[8*i +: 8], 1'b0, r);
        if (op != 8'h03)
            h_u.xbyte(8'h00, 1'b0, r);
        chk("rd_start", n0 + 1, n_rd);
        chk("rd_busy", 1, rd_busy);
        chk("rd_addr", e, rd_addr);
        chk("rd_page", a[18:8], rd_page);
        chk("rd_block", a[18:12], rd_block);
        for (int k = 0; k < nb; k++) begin
            h_u.xbyte(8'hFF, dual, r);
            chk("rd_data", fx(e), r);
            e++;
        end
        h_u.stop();
        chk("so_oe", 0, so_oe);
        chk("si_oe", 0, d_si_oe);
        chk("rd_busy", 0, rd_busy);
        chk("fill_ready", 0, fr);
    endtask

    task cmdf(input logic [7:0] op, input int na, input logic [31:0] a);
        logic [7:0] r;
        h_u.start(1'b0);
        h_u.xbyte(op, 1'b0, r);
        for (int i = 0; i < na; i++)
            h_u.xbyte(a[31-8*i -: 8], 1'b0, r);
        h_u.stop();
    endtask

    // ====================
    // scenarios
    task t_slow();
        rd(8'h03, 24'hF801FE, 1'b0, 3, 1'b0);
    endtask

    task t_fast();
        rd(8'h0B, 24'h07FFFF, 1'b1, 2, 1'b0);
    endtask

    task t_dual();
        rd(8'h3B, 24'h001000, 1'b0, 2, 1'b1);
    endtask

    task t_cmd();
        cmdf(8'h20, 3, 32'hE0123400);
        chk("cmd_cnt", 1, n_cmd);
        chk("cmd_op", 8'h20, cmd_op);
        chk("cmd_addr", 19'h01234, cmd_addr);
        chk("cmd_ha", 1, cmd_ha);
        cmdf(8'h06, 0, 32'h0);
        chk("cmd_op", 8'h06, cmd_op);
        chk("cmd_ha", 0, cmd_ha);
        cmdf(8'h02, 4, 32'h000010A5);
        chk("cmd_addr", 19'h00010, cmd_addr);
        chk("wr_cnt", 1, n_wr);
        chk("wr_data", 8'hA5, wr_d);
    endtask

    task t_bad();
        cmdf(8'h77, 4, 32'h03000000);
        chk("cmd_cnt", 3, n_cmd);
        chk("rd_cnt", 3, n_rd);
        chk("cmd_op", 8'h02, cmd_op);
    endtask

    task t_abort();
        cmdf(8'h03, 2, 32'h00010000);
        cmdf(8'h20, 2, 32'h00010000);
        chk("rd_cnt", 3, n_rd);
        chk("cmd_cnt", 3, n_cmd);
    endtask

    task results();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        // host steps are 62.5 ns; this offset keeps every pin change off a sampling edge
        #1;
        t_slow();
        t_fast();
        t_dual();
        t_cmd();
        t_bad();
        t_abort();
        chk("underrun", 0, n_und);
        results();
    end
endmodule // tb_top

`default_nettype wire
